// >>> rtl/cbt_pkg.sv
// Constants, register map and field layout for the bit timing and burst read block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package cbt_pkg;
  localparam int CBT_NBUF = 32;
  localparam int CBT_WPB = 13;
  // Register byte offsets
  localparam logic [11:0] CBT_OFS_GST = 12'h000;
  localparam logic [11:0] CBT_OFS_GIRQ = 12'h004;
  localparam logic [11:0] CBT_OFS_CTRL = 12'h010;
  localparam logic [11:0] CBT_OFS_IE = 12'h014;
  localparam logic [11:0] CBT_OFS_IRQ = 12'h018;
  localparam logic [11:0] CBT_OFS_BRP = 12'h01C;
  localparam logic [11:0] CBT_OFS_SYNC = 12'h020;
  localparam logic [11:0] CBT_OFS_TMP = 12'h024;
  localparam logic [11:0] CBT_OFS_EVT = 12'h028;
  localparam logic [11:0] CBT_OFS_MB = 12'h400;
  // Message buffer word index within a buffer (16 words per buffer)
  localparam logic [3:0] CBT_MB_LEN = 4'h0;
  localparam logic [3:0] CBT_MB_IDH = 4'hC;
  localparam logic [3:0] CBT_MB_CONF = 4'hD;
  localparam logic [3:0] CBT_MB_STAT = 4'hE;
  // Field positions
  localparam int CBT_SYNC_BT_LSB = 0;
  localparam int CBT_SYNC_SP_LSB = 5;
  localparam int CBT_SYNC_SJ_LSB = 10;
  localparam int CBT_SYNC_SAMPLING_COUNT_SELECT = 12;
  localparam int CBT_GST_GOM = 0;
  localparam int CBT_GST_TSM = 1;
  localparam int CBT_GST_FORCED_SHUTDOWN_ENABLE = 2;
  localparam int CBT_CTRL_INIT = 0;
  localparam int CBT_CTRL_INIT_STATUS_BIT = 1;
  localparam int CBT_ST_NEWDATA = 0;
  localparam int CBT_CF_IE = 0;
  localparam int CBT_CF_RMDE = 1;
  // Module irq bits: 0 rx, 1 remote, 2 tx, 3 bus error, 4 mode change, 5 overrun
  localparam int CBT_NIRQ = 6;
  // Global irq bits: 0 undefined, 1 bad shutdown, 2 ctrl/ie/irq/brp/sync w/o gom, 3 tmp with gom
  localparam int CBT_NGIRQ = 4;
  localparam logic [15:0] CBT_SYNC_RST = 16'h0218;
  localparam logic [15:0] CBT_CTRL_RST = 16'h0003;
  typedef enum logic [1:0] {
    CBT_SEG_SYNC = 2'b00,
    CBT_SEG_PH1 = 2'b01,
    CBT_SEG_PH2 = 2'b10
  } cbt_seg_e;
endpackage

// >>> rtl/cbt_quantum_gen.sv
// Time quantum enable generator and bit segment sequencer.
// Assumes timing fields are held stable outside init mode.
`timescale 1ns/1ps
module cbt_quantum_gen
  import cbt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic run,
  input wire logic [5:0] prescaler_divisor_field,
  input wire logic [4:0] bit_time_field,
  input wire logic [4:0] sample_point_field,
  input wire logic [1:0] jump_width_field,
  // Resync request: late flag and unsigned phase error magnitude in quanta
  input wire logic resync_req,
  input wire logic resync_late,
  input wire logic [4:0] resync_err,
  // Timing outputs
  output logic tq_en,
  output logic sample_pulse,
  output logic bit_start
);
  logic [6:0] pre_ff, nxt_pre;
  logic [5:0] tq_ff, nxt_tq;
  logic [6:0] div_max;
  logic [5:0] jump, sjw_q, lim_bt;
  assign div_max = 7'({prescaler_divisor_field, 1'b1});
  assign sjw_q = 6'(jump_width_field) + 6'h01;
  assign jump = (6'(resync_err) > sjw_q) ? sjw_q : 6'(resync_err);
  assign lim_bt = 6'(bit_time_field) + (resync_late ? jump : 6'h00);
  assign nxt_pre = (!run || pre_ff == div_max) ? 7'h00 : pre_ff + 7'h01;
  assign tq_en = run && (pre_ff == div_max);
  always_comb begin
    nxt_tq = tq_ff;
    if (!run) begin
      nxt_tq = 6'h00;
    end else if (tq_en) begin
      if (resync_req && !resync_late && tq_ff > 6'(sample_point_field)) begin
        nxt_tq = 6'h00;
      end else if (tq_ff >= lim_bt) begin
        nxt_tq = 6'h00;
      end else begin
        nxt_tq = tq_ff + 6'h01;
      end
    end
  end
  assign sample_pulse = tq_en && (tq_ff == 6'(sample_point_field));
  assign bit_start = tq_en && (nxt_tq == 6'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 7'h00;
      tq_ff <= 6'h00;
    end else begin
      pre_ff <= nxt_pre;
      tq_ff <= nxt_tq;
    end
  end
  // Independent count of clocks since the last quantum pulse
  logic [7:0] span_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_ff <= 8'h00;
    end else if (!run || tq_en) begin
      span_ff <= 8'h00;
    end else begin
      span_ff <= span_ff + 8'h01;
    end
  end
  property p_tq_period;
    @(posedge pclk) disable iff (!presetn)
      tq_en && $stable(prescaler_divisor_field) |-> span_ff == 8'(div_max);
  endproperty
  a_tq_period: assert property (p_tq_period) else $error("quantum pulse too close");
  property p_sample_in_bit;
    @(posedge pclk) disable iff (!presetn)
      sample_pulse |-> tq_en;
  endproperty
  a_sample_in_bit: assert property (p_sample_in_bit) else $error("sample off quantum");
  property p_one_cycle;
    @(posedge pclk) disable iff (!presetn) tq_en |=> !tq_en;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("quantum enable wider than one");
  c_sample: cover property (@(posedge pclk) sample_pulse);
endmodule

// >>> rtl/cbt_burst_buf.sv
// Temporary read buffer for burst reads of one message buffer.
// Assumes the loader presents all words in parallel, captured in the one load cycle.
`timescale 1ns/1ps
module cbt_burst_buf
  import cbt_pkg::*;
#(
  parameter int DW = 16
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Capture
  input wire logic load,
  input wire logic [DW*CBT_WPB-1:0] load_data,
  // Read side
  input wire logic [3:0] rd_idx,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] tmp_ff [CBT_WPB];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CBT_WPB; i++) tmp_ff[i] <= '0;
    end else if (load) begin
      for (int i = 0; i < CBT_WPB; i++) tmp_ff[i] <= load_data[i*DW +: DW];
    end
  end
  assign rd_data = (rd_idx < 4'(CBT_WPB)) ? tmp_ff[rd_idx] : '0;
endmodule

// >>> rtl/cbt_top.sv
// Bit timing, burst read and interrupt control of a CAN controller.
// Assumes an APB master; protocol engine events arrive as one-cycle pulses.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module cbt_top
  import cbt_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol engine events
  input wire logic store_valid,
  input wire logic [4:0] store_buf,
  input wire logic [15:0] store_word [CBT_WPB],
  input wire logic [2:0] evt_buf_kind,
  input wire logic bus_error,
  input wire logic overrun_error,
  input wire logic mode_change,
  input wire logic resync_req,
  input wire logic resync_late,
  input wire logic [4:0] resync_err,
  // Timing and interrupts
  output logic tq_en,
  output logic sample_pulse,
  output logic bit_start,
  output logic module_irq,
  output logic global_irq
);
  logic [15:0] mb_ff [CBT_NBUF][16];
  logic [2:0] gst_ff;
  logic [1:0] ctrl_ff;
  logic [5:0] ie_ff, irq_ff;
  logic [3:0] girq_ff;
  logic [5:0] brp_ff;
  logic [15:0] sync_ff;
  logic burst_ff;
  logic [4:0] bbuf_ff;
  logic [3:0] bidx_ff;
  logic [15:0] tmp_rd;
  logic [16*CBT_WPB-1:0] load_bus;
  // Decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire [5:0] mb_row = paddr[11:6] - CBT_OFS_MB[11:6];
  wire in_mb = paddr >= CBT_OFS_MB && mb_row < 6'(CBT_NBUF) && paddr[1:0] == 2'b00;
  wire [4:0] mb_n = mb_row[4:0];
  wire [3:0] mb_w = paddr[5:2];
  wire hit_gst = paddr == CBT_OFS_GST;
  wire hit_girq = paddr == CBT_OFS_GIRQ;
  wire hit_ctrl = paddr == CBT_OFS_CTRL;
  wire hit_ie = paddr == CBT_OFS_IE;
  wire hit_irq = paddr == CBT_OFS_IRQ;
  wire hit_brp = paddr == CBT_OFS_BRP;
  wire hit_sync = paddr == CBT_OFS_SYNC;
  wire hit_tmp = paddr == CBT_OFS_TMP;
  wire hit_mbv = in_mb && mb_w <= CBT_MB_STAT;
  wire hit_mod = hit_ctrl || hit_ie || hit_irq || hit_brp || hit_sync;
  wire mapped = hit_gst || hit_girq || hit_mod || hit_tmp || hit_mbv;
  wire global_operation_bit = gst_ff[CBT_GST_GOM];
  wire init_req = ctrl_ff[CBT_CTRL_INIT];
  wire rd16 = pstrb == 4'h0 || pstrb[1:0] == 2'b11;
  wire burst_go = rd && hit_mbv && mb_w == CBT_MB_LEN && rd16;
  wire burst_hit = rd && burst_ff && in_mb && mb_n == bbuf_ff && mb_w == bidx_ff
                   && bidx_ff <= CBT_MB_IDH;
  wire burst_kill = rd && burst_ff && !burst_hit;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  // Timing register and prescaler
  wire sync_we = wr && hit_sync && init_req && pstrb[1:0] == 2'b11;
  cbt_quantum_gen u_qgen (
    .pclk(pclk),
    .presetn(presetn),
    .run(global_operation_bit && !init_req),
    .prescaler_divisor_field(brp_ff),
    .bit_time_field(sync_ff[CBT_SYNC_BT_LSB +: 5]),
    .sample_point_field(sync_ff[CBT_SYNC_SP_LSB +: 5]),
    .jump_width_field(sync_ff[CBT_SYNC_SJ_LSB +: 2]),
    .resync_req(resync_req),
    .resync_late(resync_late),
    .resync_err(resync_err),
    .tq_en(tq_en),
    .sample_pulse(sample_pulse),
    .bit_start(bit_start)
  );
  // Burst copy of the addressed buffer
  genvar g;
  for (g = 0; g < CBT_WPB; g++) begin : g_load
    assign load_bus[g*16 +: 16] = mb_ff[mb_n][g];
  end
  cbt_burst_buf #(.DW(16)) u_burst (
    .pclk(pclk),
    .presetn(presetn),
    .load(burst_go),
    .load_data(load_bus),
    .rd_idx(mb_w),
    .rd_data(tmp_rd)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_ff <= 1'b0;
      bbuf_ff <= 5'h00;
      bidx_ff <= 4'h0;
    end else if (burst_go) begin
      burst_ff <= 1'b1;
      bbuf_ff <= mb_n;
      bidx_ff <= 4'h1;
    end else if (burst_hit) begin
      burst_ff <= bidx_ff != CBT_MB_IDH;
      bidx_ff <= bidx_ff + 4'h1;
    end else if (burst_kill) begin
      burst_ff <= 1'b0;
    end
  end
  // Message buffer storage with new-data flag
  wire [CBT_NBUF-1:0] stat_clr;
  for (g = 0; g < CBT_NBUF; g++) begin : g_mb
    assign stat_clr[g] = wr && hit_mbv && mb_n == 5'(g) && mb_w == CBT_MB_STAT
                         && !pwdata[CBT_ST_NEWDATA];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int w = 0; w < 16; w++) mb_ff[g][w] <= 16'h0000;
      end else begin
        for (int w = 0; w < CBT_WPB; w++) begin
          if (store_valid && store_buf == 5'(g)) begin
            mb_ff[g][w] <= store_word[w];
          end else if (wr && hit_mbv && mb_n == 5'(g) && mb_w == 4'(w)) begin
            mb_ff[g][w] <= pwdata[15:0];
          end
        end
        if (wr && hit_mbv && mb_n == 5'(g) && mb_w == CBT_MB_CONF) begin
          mb_ff[g][CBT_MB_CONF] <= pwdata[15:0];
        end
        if (store_valid && store_buf == 5'(g)) begin
          mb_ff[g][CBT_MB_STAT][CBT_ST_NEWDATA] <= 1'b1;
        end else if (stat_clr[g]) begin
          mb_ff[g][CBT_MB_STAT][CBT_ST_NEWDATA] <= 1'b0;
        end
      end
    end
  end
  // Module interrupt sources
  wire [15:0] evt_conf = mb_ff[store_buf][CBT_MB_CONF];
  wire buf_ie = evt_conf[CBT_CF_IE];
  wire ev_rx = store_valid && buf_ie && evt_buf_kind[0];
  wire ev_rem = store_valid && buf_ie && evt_buf_kind[1] && !evt_conf[CBT_CF_RMDE];
  wire ev_tx = store_valid && buf_ie && evt_buf_kind[2];
  wire [5:0] msrc = {overrun_error, mode_change, bus_error, ev_tx, ev_rem, ev_rx};
  wire [5:0] mset = msrc & ie_ff;
  wire [5:0] mclr = (wr && hit_irq) ? pwdata[5:0] : 6'h00;
  // Global interface sources
  wire gom_clr = wr && hit_gst && global_operation_bit && !pwdata[CBT_GST_GOM];
  wire [3:0] gset;
  assign gset[0] = acc && !mapped;
  assign gset[1] = gom_clr && !ctrl_ff[CBT_CTRL_INIT_STATUS_BIT] && !gst_ff[CBT_GST_FORCED_SHUTDOWN_ENABLE];
  assign gset[2] = acc && hit_mod && !global_operation_bit;
  assign gset[3] = acc && hit_tmp && global_operation_bit;
  wire [3:0] gclr = (wr && hit_girq) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gst_ff <= 3'b000;
      ctrl_ff <= 2'(CBT_CTRL_RST);
      ie_ff <= 6'h00;
      irq_ff <= 6'h00;
      girq_ff <= 4'h0;
      brp_ff <= 6'h00;
      sync_ff <= CBT_SYNC_RST;
    end else begin
      irq_ff <= (irq_ff & ~mclr) | mset;
      girq_ff <= (girq_ff & ~gclr) | gset;
      if (wr && hit_gst) gst_ff <= pwdata[2:0];
      if (wr && hit_ctrl) ctrl_ff <= {pwdata[CBT_CTRL_INIT], pwdata[CBT_CTRL_INIT]};
      if (wr && hit_ie) ie_ff <= pwdata[5:0];
      if (wr && hit_brp && init_req) brp_ff <= pwdata[5:0];
      if (sync_we) sync_ff <= {3'b000, pwdata[12:0]};
    end
  end
  assign module_irq = |irq_ff;
  assign global_irq = |girq_ff;
  // Read data
  logic [15:0] rmux;
  always_comb begin
    rmux = 16'h0000;
    if (hit_gst) rmux = {13'h0000, gst_ff};
    else if (hit_girq) rmux = {12'h000, girq_ff};
    else if (hit_ctrl) rmux = {14'h0000, ctrl_ff};
    else if (hit_ie) rmux = {10'h000, ie_ff};
    else if (hit_irq) rmux = {10'h000, irq_ff};
    else if (hit_brp) rmux = {10'h000, brp_ff};
    else if (hit_sync) rmux = sync_ff;
    else if (burst_hit) rmux = tmp_rd;
    else if (hit_mbv) rmux = mb_ff[mb_n][mb_w];
  end
  assign prdata = {16'h0000, rmux};
  property p_sync_locked;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_sync && !init_req |=> $stable(sync_ff);
  endproperty
  a_sync_locked: assert property (p_sync_locked) else $error("timing written outside init");
  property p_byte_no_burst;
    @(posedge pclk) disable iff (!presetn)
      rd && hit_mbv && mb_w == CBT_MB_LEN && !rd16 && !burst_ff |=> !burst_ff;
  endproperty
  a_byte_no_burst: assert property (p_byte_no_burst) else $error("byte read began burst");
  property p_burst_start;
    @(posedge pclk) disable iff (!presetn) burst_go |=> burst_ff && bidx_ff == 4'h1;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst not started");
  property p_burst_cancel;
    @(posedge pclk) disable iff (!presetn) burst_kill && !burst_go |=> !burst_ff;
  endproperty
  a_burst_cancel: assert property (p_burst_cancel) else $error("burst not cancelled");
  property p_newdata;
    @(posedge pclk) disable iff (!presetn)
      store_valid |=> mb_ff[$past(store_buf)][CBT_MB_STAT][CBT_ST_NEWDATA];
  endproperty
  a_newdata: assert property (p_newdata) else $error("new data flag missing");
  property p_undef_irq;
    @(posedge pclk) disable iff (!presetn) acc && !mapped |=> girq_ff[0] && global_irq;
  endproperty
  a_undef_irq: assert property (p_undef_irq) else $error("undefined access no irq");
  property p_mod_irq;
    @(posedge pclk) disable iff (!presetn) |(msrc & ie_ff) |=> module_irq;
  endproperty
  a_mod_irq: assert property (p_mod_irq) else $error("enabled event no irq");
  property p_tmp_irq;
    @(posedge pclk) disable iff (!presetn) acc && hit_tmp && global_operation_bit |=> girq_ff[3];
  endproperty
  a_tmp_irq: assert property (p_tmp_irq) else $error("temp access irq missing");
  property p_bad_shutdown;
    @(posedge pclk) disable iff (!presetn)
      gom_clr && !ctrl_ff[CBT_CTRL_INIT_STATUS_BIT] && !gst_ff[CBT_GST_FORCED_SHUTDOWN_ENABLE] |=> girq_ff[1];
  endproperty
  a_bad_shutdown: assert property (p_bad_shutdown) else $error("bad shutdown no irq");
  property p_shutdown_ok;
    @(posedge pclk) disable iff (!presetn)
      gom_clr && (ctrl_ff[CBT_CTRL_INIT_STATUS_BIT] || gst_ff[CBT_GST_FORCED_SHUTDOWN_ENABLE]) && !girq_ff[1]
      |=> !girq_ff[1];
  endproperty
  a_shutdown_ok: assert property (p_shutdown_ok) else $error("stop irq wrong");
  property p_no_gom_irq;
    @(posedge pclk) disable iff (!presetn)
      acc && hit_mod && !global_operation_bit |=> girq_ff[2];
  endproperty
  a_no_gom_irq: assert property (p_no_gom_irq) else $error("idle access no irq");
  property p_rx_irq;
    @(posedge pclk) disable iff (!presetn)
      ev_rx && ie_ff[0] |=> irq_ff[0];
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive no irq");
  property p_auto_answer;
    @(posedge pclk) disable iff (!presetn)
      store_valid && evt_buf_kind[1] && evt_conf[CBT_CF_RMDE] && !irq_ff[1] |=> !irq_ff[1];
  endproperty
  a_auto_answer: assert property (p_auto_answer) else $error("auto answer raised irq");
  property p_tx_irq;
    @(posedge pclk) disable iff (!presetn)
      ev_tx && ie_ff[2] |=> irq_ff[2];
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit no irq");
  property p_err_irq;
    @(posedge pclk) disable iff (!presetn)
      bus_error && ie_ff[3] |=> irq_ff[3];
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("bus error no irq");
  property p_overrun_irq;
    @(posedge pclk) disable iff (!presetn)
      overrun_error && ie_ff[5] |=> irq_ff[5];
  endproperty
  a_overrun_irq: assert property (p_overrun_irq) else $error("overrun no irq");
  property p_mode_irq;
    @(posedge pclk) disable iff (!presetn)
      mode_change && ie_ff[4] |=> irq_ff[4];
  endproperty
  a_mode_irq: assert property (p_mode_irq) else $error("mode change no irq");
  property p_burst_step;
    @(posedge pclk) disable iff (!presetn)
      burst_hit && bidx_ff != CBT_MB_IDH |=> burst_ff && bidx_ff == $past(bidx_ff) + 4'h1;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst did not advance");
  property p_burst_end;
    @(posedge pclk) disable iff (!presetn)
      burst_hit && bidx_ff == CBT_MB_IDH |=> !burst_ff;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst ran past last word");
  property p_newdata_clr;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_mbv && mb_w == CBT_MB_STAT && !pwdata[CBT_ST_NEWDATA]
      && !(store_valid && store_buf == mb_n)
      |=> !mb_ff[$past(mb_n)][CBT_MB_STAT][CBT_ST_NEWDATA];
  endproperty
  a_newdata_clr: assert property (p_newdata_clr) else $error("new data flag not cleared");
  property p_brp_locked;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_brp && !init_req |=> $stable(brp_ff);
  endproperty
  a_brp_locked: assert property (p_brp_locked) else $error("prescaler written outside init");
  c_burst_full: cover property (@(posedge pclk) burst_hit && bidx_ff == CBT_MB_IDH);
  c_shutdown_irq: cover property (@(posedge pclk) gset[1]);
  c_remote: cover property (@(posedge pclk) ev_rem);
endmodule

// >>> verification/cbt_engine_model.sv
// Behavioural protocol engine standing on the far side of the block.
// Assumes bench commands arrive as one-cycle pulses on go and err_go.
`timescale 1ns/1ps
module cbt_engine_model
  import cbt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic go,
  input wire logic [4:0] bnum,
  input wire logic [2:0] kind,
  input wire logic [15:0] seed,
  input wire logic [2:0] err_go,
  input wire logic [4:0] rs_go,
  // Engine side
  output logic store_valid,
  output logic [4:0] store_buf,
  output logic [15:0] store_word [CBT_WPB],
  output logic [2:0] evt_buf_kind,
  output logic bus_error,
  output logic overrun_error,
  output logic mode_change,
  output logic resync_req,
  output logic resync_late,
  output logic [4:0] resync_err
);
  // Late edge held while rs_go is nonzero, error in quanta
  assign resync_req = |rs_go;
  assign resync_late = |rs_go;
  assign resync_err = rs_go;
  // Idle bus lines toggle so stale words are never mistaken for data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_valid <= 1'b0;
      store_buf <= 5'h00;
      evt_buf_kind <= 3'h0;
      {overrun_error, mode_change, bus_error} <= 3'h0;
      for (int w = 0; w < CBT_WPB; w++) store_word[w] <= 16'h0000;
    end else begin
      store_valid <= go;
      store_buf <= go ? bnum : ~store_buf;
      evt_buf_kind <= go ? kind : 3'h0;
      {overrun_error, mode_change, bus_error} <= err_go;
      for (int w = 0; w < CBT_WPB; w++) store_word[w] <= go ? 16'(seed + w) : ~store_word[w];
    end
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench: APB master, engine model, timing and interrupt checks.
// Assumes a zero-wait APB slave and a 25 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import cbt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [3:0] pstrb;
  logic store_valid, bus_error, overrun_error, mode_change, resync_req, resync_late;
  logic [4:0] store_buf, resync_err, bnum, rs;
  logic [15:0] store_word [CBT_WPB];
  logic [2:0] evt_buf_kind, kind, err_go;
  logic tq_en, sample_pulse, bit_start, module_irq, global_irq, go;
  logic [15:0] seed, s;
  int mismatches, cmp_count, a, bt, sp, sj, cyc, q, n, i, w;

  cbt_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .store_valid(store_valid), .store_buf(store_buf),
    .store_word(store_word), .evt_buf_kind(evt_buf_kind), .bus_error(bus_error),
    .overrun_error(overrun_error), .mode_change(mode_change), .resync_req(resync_req),
    .resync_late(resync_late), .resync_err(resync_err), .tq_en(tq_en),
    .sample_pulse(sample_pulse), .bit_start(bit_start), .module_irq(module_irq),
    .global_irq(global_irq));
  cbt_engine_model eng_u (.pclk(pclk), .presetn(presetn), .go(go), .bnum(bnum), .rs_go(rs),
    .kind(kind), .seed(seed), .err_go(err_go), .store_valid(store_valid),
    .store_buf(store_buf), .store_word(store_word), .evt_buf_kind(evt_buf_kind),
    .bus_error(bus_error), .overrun_error(overrun_error), .mode_change(mode_change),
    .resync_req(resync_req), .resync_late(resync_late), .resync_err(resync_err));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                     input logic [3:0] st);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    pstrb <= wr ? 4'hF : st;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) chk("pready", 32'h0, 32'h1);
  endtask

  function automatic logic [11:0] mb(int b, int x);
    return 12'(CBT_OFS_MB + b * 64 + x * 4);
  endfunction

  task automatic store(input int b, input logic [2:0] k, input logic [15:0] sd);
    @(posedge pclk);
    go <= 1'b1;
    bnum <= 5'(b);
    kind <= k;
    seed <= sd;
    @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic ev(int x);
    return x == 0 ? tq_en : (x == 1 ? bit_start : sample_pulse);
  endfunction

  // Clocks and quanta from one event to the next
  task automatic gap(input int x, input int y);
    int t;
    t = 0;
    cyc = 0;
    q = 0;
    while (ev(x) !== 1'b1 && t < 5000) begin
      @(posedge pclk);
      t++;
    end
    do begin
      @(posedge pclk);
      cyc++;
      if (tq_en === 1'b1) q++;
    end while (ev(y) !== 1'b1 && cyc < 5000);
  endtask

  initial begin
    #(40 * 60000);
    mismatches++;
    test_done();
  end

  initial begin
    {presetn, psel, penable, pwrite, go} = 5'h0;
    {paddr, pwdata, pstrb, bnum, kind, seed, err_go, rs} = '0;
    mismatches = 0;
    cmp_count = 0;
    r = $urandom(32'h87d9);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CBT_OFS_SYNC, 0, 0);
    chk("sync_reset", r, {16'h0, CBT_SYNC_RST});
    chk("slverr_mapped", {31'h0, e}, 32'h0);
    apb(0, CBT_OFS_CTRL, 0, 0);
    chk("ctrl_reset", r, {16'h0, CBT_CTRL_RST});
    apb(0, CBT_OFS_GIRQ, 0, 0);
    chk("girq_no_gom", r & 32'h4, 32'h4);
    apb(1, CBT_OFS_GIRQ, 32'hF, 0);
    apb(1, CBT_OFS_GST, 32'h3, 0);
    chk("girq_clear", {31'h0, global_irq}, 32'h0);
    $display("Test reset done");
    for (i = 0; i < 4; i++) begin
      sp = 4 + $urandom % 9;
      bt = sp + 4 + $urandom % 9;
      sj = $urandom % 4;
      a = $urandom % 8;
      if (i == 0) {a, bt, sp, sj} = {32'd0, 32'd7, 32'd4, 32'd0};
      if (i == 1) {a, bt, sp, sj} = {32'd63, 32'd24, 32'd16, 32'd3};
      v = 32'((sj << 10) | (sp << 5) | bt);
      apb(1, CBT_OFS_CTRL, 32'h1, 0);
      apb(1, CBT_OFS_BRP, 32'(a), 0);
      apb(1, CBT_OFS_SYNC, v, 0);
      apb(1, CBT_OFS_CTRL, 32'h0, 0);
      apb(1, CBT_OFS_SYNC, ~v & 32'hFFF, 0);
      apb(0, CBT_OFS_SYNC, 0, 0);
      chk("sync_locked", r, v);
      gap(0, 0);
      chk("tq_period", 32'(cyc), 32'((a + 1) * 2));
      gap(1, 1);
      chk("bit_quanta", 32'(q), 32'(bt + 1));
      gap(1, 2);
      chk("sample_quanta", 32'(q), 32'(sp + 1));
      rs <= 5'(1 + $urandom % 6);
      gap(1, 1);
      chk("jump_quanta", 32'(q), 32'(bt + 1 + (rs > sj + 1 ? sj + 1 : rs)));
      rs <= 5'h00;
    end
    $display("Test timing done");
    n = $urandom % 32;
    apb(1, CBT_OFS_IE, 32'h3F, 0);
    apb(1, mb(n, 13), 32'h1, 0);
    for (i = 0; i < 6; i++) begin
      if (i < 3) store(n, 3'(1 << i), 16'($urandom));
      else begin
        @(posedge pclk);
        err_go <= 3'(1 << (i - 3));
        @(posedge pclk);
        err_go <= 3'h0;
        repeat (3) @(posedge pclk);
      end
      apb(0, CBT_OFS_IRQ, 0, 0);
      chk("irq_event", r, 32'(1 << i));
      chk("irq_line", {31'h0, module_irq}, 32'h1);
      apb(1, CBT_OFS_IRQ, 32'h3F, 0);
    end
    apb(1, mb(n, 13), 32'h3, 0);
    store(n, 3'h2, 16'h1234);
    apb(1, mb(n, 13), 32'h0, 0);
    store(n, 3'h1, 16'h2345);
    apb(1, CBT_OFS_IE, 32'h0, 0);
    @(posedge pclk);
    err_go <= 3'h7;
    @(posedge pclk);
    err_go <= 3'h0;
    repeat (3) @(posedge pclk);
    apb(0, CBT_OFS_IRQ, 0, 0);
    chk("irq_masked", r, 32'h0);
    $display("Test interrupts done");
    s = 16'($urandom);
    store(n, 3'h1, s);
    apb(0, mb(n, 14), 0, 0);
    chk("new_data_set", r & 32'h1, 32'h1);
    apb(0, mb(n, 0), 0, 0);
    chk("burst_len", r, {16'h0, s});
    store(n, 3'h1, ~s);
    for (w = 1; w < 13; w++) begin
      apb(0, mb(n, w), 0, 0);
      chk("burst_word", r, {16'h0, 16'(s + w)});
    end
    apb(1, mb(n, 14), 32'h0, 0);
    apb(0, mb(n, 14), 0, 0);
    chk("new_data_clr", r & 32'h1, 32'h0);
    apb(0, mb(n, 0), 0, 0);
    store(n, 3'h1, s + 16'h0100);
    apb(0, mb(n, 2), 0, 0);
    chk("skip_cancel", r, {16'h0, 16'(s + 16'h0102)});
    apb(0, mb(n, 0), 0, 0);
    store(n, 3'h1, s + 16'h0200);
    apb(0, CBT_OFS_SYNC, 0, 0);
    apb(0, mb(n, 1), 0, 0);
    chk("low_cancel", r, {16'h0, 16'(s + 16'h0201)});
    apb(0, mb(n, 0), 0, 4'h1);
    store(n, 3'h1, s + 16'h0300);
    apb(0, mb(n, 1), 0, 0);
    chk("byte_no_burst", r, {16'h0, 16'(s + 16'h0301)});
    $display("Test burst done");
    apb(0, 12'h030, 0, 0);
    chk("slverr_undef", {31'h0, e}, 32'h1);
    apb(0, CBT_OFS_TMP, 0, 0);
    apb(1, CBT_OFS_GST, 32'h0, 0);
    apb(0, CBT_OFS_GIRQ, 0, 0);
    chk("girq_events", r & 32'hB, 32'hB);
    apb(1, CBT_OFS_GIRQ, 32'hF, 0);
    apb(1, CBT_OFS_GST, 32'h3, 0);
    apb(1, CBT_OFS_CTRL, 32'h1, 0);
    apb(1, CBT_OFS_GST, 32'h1, 0);
    apb(1, CBT_OFS_GST, 32'h0, 0);
    apb(0, CBT_OFS_GIRQ, 0, 0);
    chk("orderly_stop", r & 32'h2, 32'h0);
    $display("Test global done");
    test_done();
  end
endmodule
